// ===== common/cmp_timer_pkg.sv
package cmp_timer_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_OUTCTL  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0c;
  localparam logic [7:0] OFS_CMP0    = 8'h10;
  localparam logic [7:0] OFS_CMP1    = 8'h14;
  localparam logic [7:0] OFS_ISTAT   = 8'h18;
  localparam logic [7:0] OFS_IMASK   = 8'h1c;
  localparam logic [7:0] OFS_PORT    = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  // timer_ctrl0 fields
  localparam int C0_RUN     = 0;
  localparam int C0_STOP_LO = 1;
  localparam int C0_STOP_HI = 2;
  localparam int C0_SRC_LSB = 3;
  localparam int C0_W       = 5;
  // timer_ctrl1 fields
  localparam int C1_FILT_EN  = 0;
  localparam int C1_FCLK_LSB = 1;
  localparam int C1_CLR      = 3;
  localparam int C1_ACT0_LSB = 4;
  localparam int C1_ACT1_LSB = 6;
  localparam int C1_W        = 8;
  // output_pin_ctrl fields
  localparam int NPINS      = 6;
  localparam int OC_INV_A   = 6;
  localparam int OC_INV_B   = 7;
  localparam int OC_W       = 8;
  localparam int GRP        = 3;
  // interrupt bits
  localparam int IRQ_CMP0 = 0;
  localparam int IRQ_CMP1 = 1;
  localparam int IRQ_OVF  = 2;
  localparam int NIRQ     = 3;
  // status bits
  localparam int ST_FILT = 0;
  localparam int ST_RUN  = 1;
  // widths and reset values
  localparam int CW = 16;
  localparam logic [CW-1:0] CNT_RST  = 16'h0000;
  localparam logic [CW-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CW-1:0] CMP_RST  = 16'hffff;
  // prescaler: divide-by-8 and divide-by-32 tick points
  localparam int PS_W = 5;
  localparam logic [2:0]      DIV8_END  = 3'h7;
  localparam logic [PS_W-1:0] DIV32_END = 5'h1f;
  // filter: samples that must agree
  localparam int FILT_N = 3;
  // count source / filter clock selection
  typedef enum logic [1:0] {
    SRC_DIV1  = 2'h0,
    SRC_DIV8  = 2'h1,
    SRC_DIV32 = 2'h2
  } src_sel_t;
  // level driven on a compare match
  typedef enum logic [1:0] {
    ACT_KEEP   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } match_act_t;
endpackage

// ===== hw/compare_pwm_timer.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module compare_pwm_timer (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      measured_pulse_in,
  output logic      [cmp_timer_pkg::NPINS-1:0] cmp_out,
  output logic                           irq
);
  import cmp_timer_pkg::*;

  logic [C0_W-1:0]  timer_ctrl0_r;    // run, stop levels, source
  logic [C1_W-1:0]  timer_ctrl1_r;    // filter, clear, match actions
  logic [OC_W-1:0]  output_pin_ctrl_r; // per-pin enable, group invert
  logic [NPINS-1:0] port_r;           // port levels / wave gate
  logic [CW-1:0]    timer_count_r;    // running count
  logic [CW-1:0]    compare0_value_r; // buffer seen by software
  logic [CW-1:0]    compare1_value_r;
  logic [CW-1:0]    cmp0_act_r;       // values used for matching
  logic [CW-1:0]    cmp1_act_r;
  logic [NIRQ-1:0]  istat_r;          // sticky events
  logic [NIRQ-1:0]  imask_r;          // interrupt enables
  logic             compare_wave_r;   // shared pwm level
  logic [PS_W-1:0]  ps_r;             // prescaler
  logic [1:0]       sync_r;           // pin synchroniser
  logic             filt_level;       // filtered input
  logic             tick_div8;
  logic             tick_div32;
  logic             count_tick;       // selected count source
  logic             filt_tick;        // selected filter clock
  logic             running;
  logic             match0;
  logic             match1;
  logic             ovf;
  logic             clr_now;
  logic             reload;           // buffered compare load point
  logic             wr;
  logic             rd_setup;
  logic             mapped;
  logic             wr_cmp0;
  logic             wr_cmp1;
  logic [NIRQ-1:0]  ev;

  // bus decode; every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // unmapped addresses answer with an error
  always_comb begin
    case (paddr)
      OFS_CTRL0, OFS_CTRL1, OFS_OUTCTL, OFS_COUNT, OFS_CMP0,
      OFS_CMP1, OFS_ISTAT, OFS_IMASK, OFS_PORT, OFS_STATUS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  assign running = timer_ctrl0_r[C0_RUN];
  assign wr_cmp0 = wr & (paddr == OFS_CMP0);
  assign wr_cmp1 = wr & (paddr == OFS_CMP1);

  // free-running prescaler gives the slower count rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= '0;
    end else begin
      ps_r <= ps_r + 1'b1;
    end
  end
  assign tick_div8  = (ps_r[2:0] == DIV8_END);
  assign tick_div32 = (ps_r == DIV32_END);

  // count source mux; the unused code falls back to div32
  always_comb begin
    case (src_sel_t'(timer_ctrl0_r[C0_SRC_LSB +: 2]))
      SRC_DIV1:  count_tick = 1'b1;
      SRC_DIV8:  count_tick = tick_div8;
      SRC_DIV32: count_tick = tick_div32;
      default:   count_tick = tick_div32;
    endcase
  end

  // filter sample clock picked the same way
  always_comb begin
    case (src_sel_t'(timer_ctrl1_r[C1_FCLK_LSB +: 2]))
      SRC_DIV1:  filt_tick = 1'b1;
      SRC_DIV8:  filt_tick = tick_div8;
      SRC_DIV32: filt_tick = tick_div32;
      default:   filt_tick = tick_div32;
    endcase
  end

  // pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[0], measured_pulse_in};
    end
  end

  pulse_filter u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (filt_tick),
    .bypass    (~timer_ctrl1_r[C1_FILT_EN]),
    .level_in  (sync_r[1]),
    .level_out (filt_level)
  );

  // matches count only on a tick, so the count sits a full
  // source period at each value
  assign match0  = running & count_tick & (timer_count_r == cmp0_act_r);
  assign match1  = running & count_tick & (timer_count_r == cmp1_act_r);
  assign clr_now = match1 & timer_ctrl1_r[C1_CLR];
  assign ovf     = running & count_tick & ~clr_now &
                   (timer_count_r == CNT_MAX);
  assign reload  = timer_ctrl1_r[C1_CLR] ? match1 : ovf;
  assign ev      = {ovf, match1, match0};

  // control register 0: run bit and stop behaviour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl0_r <= '0;
    end else if (wr & (paddr == OFS_CTRL0)) begin
      timer_ctrl0_r <= pwdata[C0_W-1:0];
    end
  end

  // control register 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl1_r <= '0;
    end else if (wr & (paddr == OFS_CTRL1)) begin
      timer_ctrl1_r <= pwdata[C1_W-1:0];
    end
  end

  // pin enables and group inversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pin_ctrl_r <= '0;
    end else if (wr & (paddr == OFS_OUTCTL)) begin
      output_pin_ctrl_r <= pwdata[OC_W-1:0];
    end
  end

  // programmable port levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_r <= '0;
    end else if (wr & (paddr == OFS_PORT)) begin
      port_r <= pwdata[NPINS-1:0];
    end
  end

  // counter: stop clears it, cmp1 may clear it, else it wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_r <= CNT_RST;
    end else if (!running) begin
      timer_count_r <= CNT_RST;
    end else if (clr_now) begin
      timer_count_r <= CNT_RST;
    end else if (count_tick) begin
      timer_count_r <= timer_count_r + 1'b1;
    end
  end

  // software-side compare buffers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare0_value_r <= CMP_RST;
      compare1_value_r <= CMP_RST;
    end else begin
      if (wr_cmp0) begin
        compare0_value_r <= pwdata[CW-1:0];
      end
      if (wr_cmp1) begin
        compare1_value_r <= pwdata[CW-1:0];
      end
    end
  end

  // active compares: direct when stopped, else at the load point
  // a write in the load cycle itself is taken at the next point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp0_act_r <= CMP_RST;
      cmp1_act_r <= CMP_RST;
    end else if (!running) begin
      cmp0_act_r <= wr_cmp0 ? pwdata[CW-1:0] : compare0_value_r;
      cmp1_act_r <= wr_cmp1 ? pwdata[CW-1:0] : compare1_value_r;
    end else if (reload) begin
      cmp0_act_r <= compare0_value_r;
      cmp1_act_r <= compare1_value_r;
    end
  end

  // pwm level; compare1 acts last so it wins a shared match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_wave_r <= 1'b0;
    end else begin
      if (match0 & !match1) begin
        case (match_act_t'(timer_ctrl1_r[C1_ACT0_LSB +: 2]))
          ACT_LOW:    compare_wave_r <= 1'b0;
          ACT_HIGH:   compare_wave_r <= 1'b1;
          ACT_TOGGLE: compare_wave_r <= ~compare_wave_r;
          default:    compare_wave_r <= compare_wave_r;
        endcase
      end else if (match1) begin
        case (match_act_t'(timer_ctrl1_r[C1_ACT1_LSB +: 2]))
          ACT_LOW:    compare_wave_r <= 1'b0;
          ACT_HIGH:   compare_wave_r <= 1'b1;
          ACT_TOGGLE: compare_wave_r <= ~compare_wave_r;
          default:    compare_wave_r <= compare_wave_r;
        endcase
      end
    end
  end

  // per-pin output select; registered so pins never glitch
  generate
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
      logic inv;   // group inversion for this pin
      logic lvl;   // level while counting
      assign inv = (i < GRP) ? output_pin_ctrl_r[OC_INV_A]
                             : output_pin_ctrl_r[OC_INV_B];
      assign lvl = (port_r[i] & compare_wave_r) ^ inv;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_out[i] <= 1'b0;
        end else if (!output_pin_ctrl_r[i]) begin
          cmp_out[i] <= port_r[i];
        end else if (running) begin
          cmp_out[i] <= lvl;
        end else if (timer_ctrl0_r[C0_STOP_LO]) begin
          cmp_out[i] <= timer_ctrl0_r[C0_STOP_HI];
        end else begin
          cmp_out[i] <= lvl;  // wave is frozen, so held
        end
      end
    end
  endgenerate

  // sticky events: a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
    end else begin
      istat_r <= ev |
        (istat_r & ~((wr & (paddr == OFS_ISTAT)) ? pwdata[NIRQ-1:0]
                                                  : {NIRQ{1'b0}}));
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= '0;
    end else if (wr & (paddr == OFS_IMASK)) begin
      imask_r <= pwdata[NIRQ-1:0];
    end
  end

  // level interrupt from a flop, one cycle behind the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_r & imask_r);
    end
  end

  // read data captured in the setup cycle, stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      case (paddr)
        OFS_CTRL0:  prdata[C0_W-1:0]  <= timer_ctrl0_r;
        OFS_CTRL1:  prdata[C1_W-1:0]  <= timer_ctrl1_r;
        OFS_OUTCTL: prdata[OC_W-1:0]  <= output_pin_ctrl_r;
        OFS_COUNT:  prdata[CW-1:0]    <= timer_count_r;
        OFS_CMP0:   prdata[CW-1:0]    <= compare0_value_r;
        OFS_CMP1:   prdata[CW-1:0]    <= compare1_value_r;
        OFS_ISTAT:  prdata[NIRQ-1:0]  <= istat_r;
        OFS_IMASK:  prdata[NIRQ-1:0]  <= imask_r;
        OFS_PORT:   prdata[NPINS-1:0] <= port_r;
        OFS_STATUS: begin
          prdata[ST_FILT] <= filt_level;
          prdata[ST_RUN]  <= running;
        end
        default:    prdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/pulse_filter.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sample_en,
  input  wire logic bypass,
  input  wire logic level_in,
  output logic      level_out
);
  import cmp_timer_pkg::*;

  logic [FILT_N-1:0] hist_r;  // last samples, newest in bit 0

  // sample history, shifted on the filter clock only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r <= '0;
    end else if (sample_en) begin
      hist_r <= {hist_r[FILT_N-2:0], level_in};
    end
  end

  // accept a level only when all samples agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b0;
    end else if (bypass) begin
      // bypass still adds one flop so the output stays registered
      level_out <= level_in;
    end else if (&hist_r) begin
      level_out <= 1'b1;
    end else if (~|hist_r) begin
      level_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== test/compare_pwm_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module compare_pwm_timer_monitor (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [7:0]                     paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic                           measured_pulse_in,
  input wire logic [cmp_timer_pkg::NPINS-1:0] cmp_out,
  input wire logic                           irq
);
  import cmp_timer_pkg::*;
  logic          run_r;  // last written run bit
  logic [7:0]    oc_r;   // last written pin control
  logic [5:0]    port_r; // last written port levels
  logic [CW-1:0] cmp0_r; // compare 0 as software wrote it
  logic [CW-1:0] cmp1_r; // compare 1 as software wrote it
  logic          wr;     // write taken at this edge
  assign wr = psel && penable && pwrite;

  // shadow writes on the same edge the block takes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r  <= 1'b0;
      oc_r   <= 8'h00;
      port_r <= 6'h00;
      cmp0_r <= CMP_RST;
      cmp1_r <= CMP_RST;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL0:  run_r <= pwdata[C0_RUN];
        OFS_OUTCTL: oc_r <= pwdata[7:0];
        OFS_PORT:   port_r <= pwdata[5:0];
        OFS_CMP0:   cmp0_r <= pwdata[CW-1:0];
        OFS_CMP1:   cmp1_r <= pwdata[CW-1:0];
        default:    ;
      endcase
    end
  end

  // access phases of one register
  sequence wr_to(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence rd_of(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  unmapped_error_a: assert property (
    psel && penable && paddr > OFS_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= OFS_STATUS
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  irq_masked_a: assert property (
    wr_to(OFS_IMASK) ##0 pwdata[NIRQ-1:0] == 3'h0 |-> ##2 !irq[*2])
    else $error("irq high with all sources masked");
  count_stopped_a: assert property (
    rd_of(OFS_COUNT) ##0 (!run_r && !$past(run_r) && !$past(run_r, 2))
    |-> prdata == 32'h0)
    else $error("count not zero while stopped");
  run_status_a: assert property (
    rd_of(OFS_STATUS) ##0 run_r == $past(run_r) |-> prdata[ST_RUN] == run_r)
    else $error("running flag differs from run bit");
  cmp0_readback_a: assert property (
    rd_of(OFS_CMP0) |-> prdata == {16'h0, cmp0_r})
    else $error("compare 0 readback wrong");
  cmp1_readback_a: assert property (
    rd_of(OFS_CMP1) |-> prdata == {16'h0, cmp1_r})
    else $error("compare 1 readback wrong");
  stop_force_a: assert property (
    wr_to(OFS_CTRL0) ##0 pwdata[2:0] == 3'h6
    |-> ##3 (cmp_out == (oc_r[5:0] | port_r))[*2])
    else $error("pins not forced high on stop");
endmodule

bind compare_pwm_timer compare_pwm_timer_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .measured_pulse_in(measured_pulse_in),
  .cmp_out(cmp_out), .irq(irq)
);
`default_nettype wire

// ===== test/compare_pwm_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module compare_pwm_timer_tb;
  import cmp_timer_pkg::*;
  logic             pclk     = 1'b0;
  logic             presetn  = 1'b0;
  logic             psel     = 1'b0;
  logic             penable  = 1'b0;
  logic             pwrite   = 1'b0;
  logic [7:0]       paddr    = 8'h00;
  logic [31:0]      pwdata   = 32'h0;
  logic             pulse_in = 1'b0; // measured input pin
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [NPINS-1:0] cmp_out;
  logic             irq;
  logic [15:0]      hi_len;  // high time seen by the load
  logic [15:0]      per_len; // period seen by the load
  logic [31:0]      rd;      // last read data
  logic             er;      // last slave error
  logic [NPINS-1:0] held;    // pins at stop
  int               errors = 0;
  int               cmp_count = 0;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } row_t;
  // direction, address, write data, read data, error
  row_t rows [18] = '{
    '{1'b0, OFS_CTRL0, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_CTRL1, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_CMP0, 32'h0, 32'hffff, 1'b0},
    '{1'b0, OFS_CMP1, 32'h0, 32'hffff, 1'b0},
    '{1'b0, OFS_ISTAT, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFS_COUNT, 32'h1234, 32'h0, 1'b0},
    '{1'b0, OFS_COUNT, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFS_CMP0, 32'habcd0003, 32'h0, 1'b0},
    '{1'b0, OFS_CMP0, 32'h0, 32'h3, 1'b0},
    '{1'b1, OFS_CMP1, 32'h9, 32'h0, 1'b0},
    '{1'b1, OFS_IMASK, 32'hff, 32'h0, 1'b0},
    '{1'b0, OFS_IMASK, 32'h0, 32'h7, 1'b0},
    '{1'b1, OFS_OUTCTL, 32'h1, 32'h0, 1'b0},
    '{1'b1, OFS_PORT, 32'h1, 32'h0, 1'b0},
    '{1'b1, OFS_CTRL1, 32'h68, 32'h0, 1'b0},
    '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'hfc, 32'h5, 32'h0, 1'b1}
  };

  always #5 pclk = ~pclk;

  compare_pwm_timer u_compare_pwm_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measured_pulse_in(pulse_in),
    .cmp_out(cmp_out), .irq(irq)
  );
  pwm_load_model u_pwm_load_model (
    .clk(pclk), .pin(cmp_out[0]), .hi_len(hi_len), .per_len(per_len)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen
  // no cycle limit here: only the watchdog may end a stalled wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] q);
    apb(1'b0, a, 32'h0);
    chk(rd, q);
  endtask

  // waits, then steps off the edge so outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic set_in(input logic v);
    @(posedge pclk);
    pulse_in <= v;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, well past the overflow wait
  initial begin
    #1000000;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    $display("test done: register map");
    // m=3 n=9, clear on compare 1, every clock
    wr(OFS_CTRL0, 32'h1);
    idle(40);
    chk({16'h0, per_len}, 32'd10);
    chk({16'h0, hi_len}, 32'd6);
    chk({31'h0, irq}, 32'h1);
    rdx(OFS_ISTAT, 32'h3);
    rdx(OFS_STATUS, 32'h2);
    wr(OFS_CMP1, 32'd19);
    idle(60);
    chk({16'h0, per_len}, 32'd20);
    chk({16'h0, hi_len}, 32'd16);
    // pin 0 fixed low, group b inverted
    wr(OFS_OUTCTL, 32'hbf);
    wr(OFS_PORT, 32'h3e);
    idle(4);
    repeat (25) begin
      chk({28'h0, cmp_out[0], cmp_out[1] ^ cmp_out[2], cmp_out[4] ^ cmp_out[1],
           cmp_out[5] ^ cmp_out[2]}, 32'h3);
      idle(1);
    end
    $display("test done: pwm waveform");
    wr(OFS_PORT, 32'h3f);
    wr(OFS_CTRL0, 32'h6);
    idle(4);
    chk({26'h0, cmp_out}, 32'h3f);
    wr(OFS_CTRL0, 32'h2);
    idle(4);
    chk({26'h0, cmp_out}, 32'h0);
    rdx(OFS_COUNT, 32'h0);
    wr(OFS_CTRL0, 32'h1);
    idle(7);
    wr(OFS_CTRL0, 32'h0);
    idle(3);
    held = cmp_out;
    idle(30);
    chk({26'h0, cmp_out}, {26'h0, held});
    $display("test done: stop levels");
    // m=1 n=3 under each count source; spare code 3 acts as div32
    wr(OFS_CMP0, 32'h1);
    wr(OFS_CMP1, 32'h3);
    for (int k = 0; k < 4; k++) begin
      int dv;
      dv = (k == 0) ? 1 : ((k == 1) ? 8 : 32);
      wr(OFS_CTRL0, 32'(1 + 8 * k));
      idle(16 * dv + 8);
      chk({16'h0, per_len}, 32'(4 * dv));
      chk({16'h0, hi_len}, 32'(2 * dv));
      wr(OFS_CTRL0, 32'h0);
    end
    // toggle on compare 0, keep on compare 1: one edge per period
    wr(OFS_CTRL1, 32'h38);
    wr(OFS_CTRL0, 32'h1);
    idle(30);
    chk({16'h0, per_len}, 32'd8);
    chk({16'h0, hi_len}, 32'd4);
    wr(OFS_CTRL0, 32'h0);
    $display("test done: count sources");
    // free running until the counter wraps
    wr(OFS_CTRL1, 32'h60);
    wr(OFS_ISTAT, 32'h7);
    wr(OFS_IMASK, 32'h4);
    rdx(OFS_ISTAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_CTRL0, 32'h1);
    idle(65556);
    rdx(OFS_ISTAT, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IMASK, 32'h0);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_CTRL0, 32'h0);
    $display("test done: overflow");
    // filter sampling every 32 clocks rejects a 21 clock pulse
    wr(OFS_CTRL1, 32'h5);
    set_in(1'b1);
    repeat (20) @(posedge pclk);
    set_in(1'b0);
    idle(70);
    rdx(OFS_STATUS, 32'h0);
    wr(OFS_CTRL1, 32'h1);
    set_in(1'b1);
    set_in(1'b1);
    set_in(1'b0);
    idle(8);
    rdx(OFS_STATUS, 32'h0);
    set_in(1'b1);
    idle(8);
    rdx(OFS_STATUS, 32'h1);
    set_in(1'b0);
    wr(OFS_CTRL1, 32'h0);
    idle(4);
    rdx(OFS_STATUS, 32'h0);
    $display("test done: input filter");
    // reset while counting: pins, interrupt and registers go back
    wr(OFS_IMASK, 32'h7);
    wr(OFS_CTRL0, 32'h1);
    idle(5);
    chk({31'h0, irq}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    idle(3);
    chk({26'h0, cmp_out}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdx(OFS_CTRL0, 32'h0);
    rdx(OFS_CMP1, 32'hffff);
    rdx(OFS_COUNT, 32'h0);
    $display("test done: reset in mid-run");
    complete_run;
  end
endmodule
`default_nettype wire

// ===== test/pwm_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
  input  wire logic        clk,
  input  wire logic        pin,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len
);
  logic [15:0] run_cnt = 16'h0; // cycles since last rise
  logic        pin_d   = 1'b0;  // pin one cycle ago
  // passive load: only times the high level and the period, places no demand on the pin
  always_ff @(posedge clk) begin
    pin_d   <= pin;
    run_cnt <= run_cnt + 16'h1;
    if (pin && !pin_d) begin
      per_len <= run_cnt;
      run_cnt <= 16'h1;
    end
    if (!pin && pin_d) begin
      hi_len <= run_cnt;
    end
  end
endmodule
`default_nettype wire
